// *** design/erm_top.v ***
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "erm_defs.vh"
// Summary of operation
// [RULE1] framing error counter, 16 bits, counts FAS errors while frame sync held
// [RULE2] alarm simulation bumps framing counter every 250 us
// [RULE3] all error counters saturate, never wrap
// [RULE4] violation counter idle in NRZ; HDB3/CMI counts HDB3 violations, variant selectable
// [RULE5] line code 10 (AMI) counts every bipolar violation
// [RULE6] alarm simulation bumps violation counter every four received bits
// [RULE7] crc counter one idle in doubleframe; counts bad submultiframes when synchronous
// [RULE8] alarm simulation bumps crc, e-bit and sa6 counters once per submultiframe
// [RULE9] e-bit counter counts zero spare bits of frames 13 and 15, multiframe only
// [RULE10] latch mode off: buffer tracks counter; freeze rising edge stops it, clears counter
// [RULE11] freeze bit clears itself on read of that counter high byte
// [RULE12] latch mode on: each second latch all counters then clear them
// [RULE13] sa6 mode 0: count sa6 groups 0010/0011 per submultiframe in multiframe sync
// [RULE14] sa6 mode 1: bits 7..2 count multiframes spent out of alignment
// [RULE15] sa6 mode 1: bits 1..0 count alignment changes, saturating
// [RULE16] sa6 mode 1: alarm simulation advances both sub-counters once per multiframe
// [RULE17] sa4..sa8 capture eight bits of previous multiframe, refresh at multiframe begin
// [RULE18] sa6 groups of four classified as 1000,1010,1100,1110,1111 or other
// [RULE19] sa6 status bit set after three repeats; read of status clears all
// [RULE20] every change of detected sa6 state raises the change flag
// [RULE21] sa6 updates blocked without frame sync; sync mode also needs multiframe sync
// [RULE22] prbs status shows synchroniser lock while monitor enabled
// [RULE23] fas spare bit only in doubleframe else 1; frame 13/15 bits else 0
// [RULE24] software reads counter low byte before high byte
module erm_top #(
    parameter ALARM_TICK_CYCLES = `ERM_ALARM_CYC
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rdata,
    input  wire       frame_sync_lost,
    input  wire       multiframe_sync_lost,
    input  wire       crc_mf_mode,
    input  wire       alarm_sim,
    input  wire       fas_error,
    input  wire       rx_bit_tick,
    input  wire       hdb3_violation,
    input  wire       hdb3_violation_ext,
    input  wire       bipolar_violation,
    input  wire       crc_error,
    input  wire       submultiframe_end,
    input  wire       multiframe_begin_interrupt,
    input  wire       alignment_change,
    input  wire       one_second_interrupt,
    input  wire       svc_bit_valid,
    input  wire [3:0] svc_frame_num,
    input  wire       svc_spare_bit,
    input  wire [4:0] svc_national_bits,
    input  wire       prbs_locked,
    output reg        sa6_change_interrupt
);

    // ==========================================================
    // register port
    // ==========================================================
    reg  [7:0]  ctrl;
    reg  [4:0]  frz;
    reg  [4:0]  frz_d;
    wire [4:0]  frz_hi_rd;
    wire [79:0] buf_flat;
    wire        latch_mode = ctrl[`ERM_CTL_LATCH];
    wire        sa6_mode   = ctrl[`ERM_CTL_SA6MODE];
    wire [1:0]  code_sel   = ctrl[`ERM_CTL_CODE_LO +: 2];
    wire [7:0]  cnt_off    = addr - `ERM_ADR_CNT;
    wire [7:0]  sa_off     = addr - `ERM_ADR_SA;
    reg  [7:0]  spare;
    reg  [7:0]  sa6_status;
    reg  [7:0]  sa_cap [0:4];
    reg  [7:0]  next_rdata;

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl  <= `ERM_CTL_RESET;
            frz   <= `ERM_FRZ_RESET;
            frz_d <= `ERM_FRZ_RESET;
        end
        else
        begin
            frz_d <= frz;
            if (wr_stb && addr == `ERM_ADR_CTRL)
                ctrl <= wdata;
            if (wr_stb && addr == `ERM_ADR_FREEZE)
                frz <= wdata[4:0];
            else
                frz <= frz & ~frz_hi_rd; // RULE11
        end
    end

    always @*
    begin
        next_rdata = 8'h00;
        if (addr == `ERM_ADR_CTRL)
            next_rdata = ctrl;
        else if (addr == `ERM_ADR_FREEZE)
            next_rdata = {3'h0, frz};
        else if (addr == `ERM_ADR_SPARE)
            next_rdata = spare;
        else if (addr >= `ERM_ADR_CNT && addr < `ERM_ADR_CNT_END)
            next_rdata = buf_flat[{cnt_off[3:0], 3'h0} +: 8];
        else if (addr >= `ERM_ADR_SA && addr < `ERM_ADR_SA_END)
            next_rdata = sa_cap[sa_off[2:0]];
        else if (addr == `ERM_ADR_SA6ST)
            next_rdata = sa6_status;
    end

    always @(posedge mclk)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (rd_stb)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end

    // ==========================================================
    // alarm simulation ticks
    // ==========================================================
    reg  [31:0] alm_div;
    reg  [1:0]  bit_div;
    wire        tick_250us = (alm_div == ALARM_TICK_CYCLES - 1);
    wire        tick_4bit  = rx_bit_tick && bit_div == 2'h3;

    always @(posedge mclk)
    begin
        if (!rst_n || !alarm_sim)
        begin
            alm_div <= 32'h0;
            bit_div <= 2'h0;
        end
        else
        begin
            alm_div <= tick_250us ? 32'h0 : alm_div + 32'h1;
            if (rx_bit_tick)
                bit_div <= bit_div + 2'h1;
        end
    end

    // ==========================================================
    // sa6 bit collection
    // ==========================================================
    wire       sa6_bit   = svc_national_bits[`ERM_SA6_IDX];
    wire       svc_word  = svc_bit_valid && svc_frame_num[0];
    // frames 7 and 15 both close a submultiframe, so the top frame bit is ignored
    wire       smf_last  = svc_word && ({1'b0, svc_frame_num[2:0]} == `ERM_FRAME_7);
    reg  [2:0] sa6_hist;
    wire [3:0] sa6_group = {sa6_hist, sa6_bit};

    always @(posedge mclk)
    begin
        if (!rst_n)
            sa6_hist <= 3'h0;
        else if (svc_word)
            sa6_hist <= {sa6_hist[1:0], sa6_bit};
    end

    // ==========================================================
    // counter increments
    // ==========================================================
    wire       crc_sync = !frame_sync_lost && !multiframe_sync_lost;
    reg        cv_event;
    wire [4:0] inc;
    wire       sa6_err  = crc_mf_mode && !multiframe_sync_lost && smf_last
                          && sa6_group[3:1] == 3'b001;
    wire       mf_inc   = multiframe_begin_interrupt
                          && (alarm_sim || frame_sync_lost || multiframe_sync_lost);
    wire       al_inc   = alarm_sim ? multiframe_begin_interrupt : alignment_change;

    always @*
    begin
        cv_event = 1'b0;
        if (code_sel == `ERM_CODE_AMI)
            cv_event = bipolar_violation; // RULE5
        else if (code_sel != `ERM_CODE_NRZ)
            cv_event = ctrl[`ERM_CTL_EXTD] ? hdb3_violation_ext : hdb3_violation; // RULE4
    end

    assign inc[0] = alarm_sim ? tick_250us : (fas_error && !frame_sync_lost); // RULE1 RULE2
    assign inc[1] = alarm_sim ? tick_4bit : cv_event; // RULE6
    assign inc[2] = crc_mf_mode && (alarm_sim ? submultiframe_end
                                              : (crc_error && crc_sync)); // RULE7 RULE8
    assign inc[3] = crc_mf_mode && (alarm_sim ? submultiframe_end // RULE8
                    : (svc_word && !svc_spare_bit && (svc_frame_num == `ERM_FRAME_13
                       || svc_frame_num == `ERM_FRAME_15))); // RULE9
    assign inc[4] = crc_mf_mode && (alarm_sim ? submultiframe_end : sa6_err); // RULE13

    function [15:0] erm_bump;
        input [15:0] cur;
        input        ev;
        input        split;
        input        mf_ev;
        input        al_ev;
        begin
            if (split)
                erm_bump = {cur[15:8],
                            (mf_ev && cur[7:2] != `ERM_MF6_MAX) ? cur[7:2] + 6'h1
                                                                : cur[7:2], // RULE14 RULE16
                            (al_ev && cur[1:0] != `ERM_AL2_MAX) ? cur[1:0] + 2'h1
                                                                : cur[1:0]}; // RULE15
            else if (ev && cur != `ERM_CNT_MAX)
                erm_bump = cur + 16'h1; // RULE3
            else
                erm_bump = cur;
        end
    endfunction

    // ==========================================================
    // counters with readout buffers
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < `ERM_NCNT; g = g + 1)
        begin : g_cnt
            reg  [15:0] cnt;
            reg  [15:0] hold;
            wire        split  = (g == `ERM_CNT_SA6) && sa6_mode;
            wire        frz_up = frz[g] && !frz_d[g];
            wire        clr    = latch_mode ? one_second_interrupt : frz_up;
            wire [15:0] base   = clr ? `ERM_CNT_ZERO : cnt;
            wire [15:0] next_cnt = erm_bump(base, inc[g], split, mf_inc, al_inc);

            // an event in the clearing cycle lands in the fresh count
            always @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    cnt  <= `ERM_CNT_ZERO;
                    hold <= `ERM_CNT_ZERO;
                end
                else
                begin
                    cnt <= next_cnt; // RULE10 RULE12
                    if (latch_mode)
                    begin
                        if (one_second_interrupt)
                            hold <= cnt; // RULE12
                    end
                    else if (!frz[g])
                        hold <= cnt; // RULE10
                end
            end

            assign buf_flat[16*g +: 16] = hold;
            assign frz_hi_rd[g] = rd_stb && addr == `ERM_ADR_CNT + 2*g + 1; // RULE24
        end
    endgenerate

    // ==========================================================
    // national bit capture
    // ==========================================================
    reg [7:0] sa_shadow [0:4];
    reg       frame13_spare_bit_sh;
    reg       frame15_spare_bit_sh;

    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_sa
            always @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    sa_shadow[g] <= 8'h00;
                    sa_cap[g]    <= 8'h00;
                end
                else
                begin
                    if (svc_word)
                        sa_shadow[g][svc_frame_num[3:1]] <= svc_national_bits[g]; // RULE17
                    if (multiframe_begin_interrupt)
                        sa_cap[g] <= sa_shadow[g]; // RULE17
                end
            end
        end
    endgenerate

    // ==========================================================
    // spare bits and prbs status
    // ==========================================================
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            spare   <= 8'h01;
            frame13_spare_bit_sh <= 1'b0;
            frame15_spare_bit_sh <= 1'b0;
        end
        else
        begin
            if (svc_word && svc_frame_num == `ERM_FRAME_13)
                frame13_spare_bit_sh <= svc_spare_bit;
            if (svc_word && svc_frame_num == `ERM_FRAME_15)
                frame15_spare_bit_sh <= svc_spare_bit;
            spare[3] <= ctrl[`ERM_CTL_PRBS] && prbs_locked; // RULE22
            if (crc_mf_mode)
            begin
                spare[0] <= 1'b1; // RULE23
                if (multiframe_begin_interrupt)
                begin
                    spare[1] <= frame13_spare_bit_sh; // RULE23
                    spare[2] <= frame15_spare_bit_sh;
                end
            end
            else
            begin
                spare[1] <= 1'b0;
                spare[2] <= 1'b0;
                if (svc_bit_valid && !svc_frame_num[0])
                    spare[0] <= svc_spare_bit; // RULE23
            end
        end
    end

    // ==========================================================
    // sa6 pattern detector
    // ==========================================================
    function [2:0] erm_sa6_class;
        input [3:0] grp;
        begin
            case (grp)
                4'h8:    erm_sa6_class = `ERM_SA6_8;
                4'ha:    erm_sa6_class = `ERM_SA6_A;
                4'hc:    erm_sa6_class = `ERM_SA6_C;
                4'he:    erm_sa6_class = `ERM_SA6_E;
                4'hf:    erm_sa6_class = `ERM_SA6_F;
                default: erm_sa6_class = `ERM_SA6_X;
            endcase
        end
    endfunction

    reg  [2:0] last_cls;
    reg  [1:0] rep;
    reg  [2:0] det_cls;
    wire [2:0] cls      = erm_sa6_class(sa6_group); // RULE18
    // sync mode checks aligned groups only; async slides one bit at a time
    wire       sa6_eval = svc_word && !frame_sync_lost
                          && (ctrl[`ERM_CTL_SA6SY] ? (smf_last && !multiframe_sync_lost)
                                                   : 1'b1); // RULE21
    wire [1:0] next_rep = (cls == last_cls && rep != `ERM_SA6_REPEAT) ? rep + 2'h1
                        : (cls == last_cls) ? rep : 2'h1;
    wire       confirm  = sa6_eval && next_rep == `ERM_SA6_REPEAT;
    wire [7:0] set_bits = confirm ? (8'h01 << cls) : 8'h00;
    wire       st_rd    = rd_stb && addr == `ERM_ADR_SA6ST;

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            last_cls             <= `ERM_SA6_NONE;
            rep                  <= 2'h0;
            det_cls              <= `ERM_SA6_NONE;
            sa6_status           <= 8'h00;
            sa6_change_interrupt <= 1'b0;
        end
        else
        begin
            if (sa6_eval)
            begin
                last_cls <= cls;
                rep      <= next_rep;
            end
            if (confirm)
                det_cls <= cls;
            sa6_change_interrupt <= confirm && cls != det_cls; // RULE20
            // a pattern confirmed during the clearing read still shows
            sa6_status <= (st_rd ? 8'h00 : sa6_status) | set_bits; // RULE19
        end
    end

endmodule // erm_top

// *** design/erm_defs.vh ***
`ifndef ERM_DEFS_VH
`define ERM_DEFS_VH

// register offsets
`define ERM_ADR_CTRL    8'h00
`define ERM_ADR_FREEZE  8'h01
`define ERM_ADR_SPARE   8'h02
`define ERM_ADR_CNT     8'h03
`define ERM_ADR_CNT_END 8'h0d
`define ERM_ADR_SA      8'h10
`define ERM_ADR_SA_END  8'h15
`define ERM_ADR_SA6ST   8'h15

// control register fields
`define ERM_CTL_LATCH   0
`define ERM_CTL_SA6MODE 1
`define ERM_CTL_EXTD    2
`define ERM_CTL_CODE_LO 3
`define ERM_CTL_PRBS    5
`define ERM_CTL_SA6SY   6
`define ERM_CTL_RESET   8'h00
`define ERM_FRZ_RESET   5'h00

// receive line codes
`define ERM_CODE_NRZ    2'b00
`define ERM_CODE_CMI    2'b01
`define ERM_CODE_AMI    2'b10
`define ERM_CODE_HDB3   2'b11

// counters
`define ERM_NCNT        5
`define ERM_CNT_SA6     4
`define ERM_CNT_MAX     16'hffff
`define ERM_CNT_ZERO    16'h0000
`define ERM_MF6_MAX     6'h3f
`define ERM_AL2_MAX     2'h3
`define ERM_FRAME_13    4'hd
`define ERM_FRAME_15    4'hf
`define ERM_FRAME_7     4'h7
`define ERM_SA6_IDX     2

// sa6 pattern classes, bit positions in the status register
`define ERM_SA6_X       3'd0
`define ERM_SA6_8       3'd1
`define ERM_SA6_A       3'd2
`define ERM_SA6_C       3'd3
`define ERM_SA6_E       3'd4
`define ERM_SA6_F       3'd5
`define ERM_SA6_NONE    3'd7
`define ERM_SA6_REPEAT  2'd3

// timing
`define ERM_ALARM_US    250
`define ERM_CLK_NS      4
`define ERM_ALARM_CYC   ((`ERM_ALARM_US * 1000) / `ERM_CLK_NS)

`endif

// *** dv/erm_asserts.sv ***
`timescale 1ns/1ps
`include "erm_defs.vh"
// ========
// port-level checks on read data and sa6 change flag
module erm_asserts (
    input wire       mclk,
    input wire       rst_n,
    input wire [7:0] addr,
    input wire       rd_stb,
    input wire [7:0] rdata,
    input wire       frame_sync_lost,
    input wire       crc_mf_mode,
    input wire       prbs_locked,
    input wire       sa6_change_interrupt
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_idle_zero;
        !rd_stb |=> rdata == 8'h00;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data outside read");

    property p_frz_clear;
        rd_stb && addr == 8'h04 ##1 rd_stb && addr == `ERM_ADR_FREEZE |=> rdata[0] == 1'b0;
    endproperty
    a_frz_clear: assert property (p_frz_clear) else $error("freeze bit kept");

    property p_chg_pulse;
        sa6_change_interrupt |=> !sa6_change_interrupt;
    endproperty
    a_chg_pulse: assert property (p_chg_pulse) else $error("change flag too long");

    property p_blocked;
        frame_sync_lost [*3] |-> !sa6_change_interrupt;
    endproperty
    a_blocked: assert property (p_blocked) else $error("change flag without sync");

    // a set landing in the first read cycle may survive, so sync loss leads in
    property p_clr_twice;
        frame_sync_lost [*2] ##1 (rd_stb && addr == `ERM_ADR_SA6ST && frame_sync_lost)
            ##1 (rd_stb && addr == `ERM_ADR_SA6ST && frame_sync_lost) |=> rdata == 8'h00;
    endproperty
    a_clr_twice: assert property (p_clr_twice) else $error("status not cleared");

    property p_prbs;
        !prbs_locked [*3] ##0 (rd_stb && addr == `ERM_ADR_SPARE) |=> rdata[3] == 1'b0;
    endproperty
    a_prbs: assert property (p_prbs) else $error("prbs status without lock");

    property p_fas_bit;
        crc_mf_mode [*3] ##0 (rd_stb && addr == `ERM_ADR_SPARE) |=> rdata[0] == 1'b1;
    endproperty
    a_fas_bit: assert property (p_fas_bit) else $error("fas spare bit not one");

    property p_mf_bits;
        !crc_mf_mode [*3] ##0 (rd_stb && addr == `ERM_ADR_SPARE) |=> rdata[2:1] == 2'b00;
    endproperty
    a_mf_bits: assert property (p_mf_bits) else $error("frame 13/15 bits set");
endmodule // erm_asserts

bind erm_top erm_asserts i_chk (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
    .frame_sync_lost(frame_sync_lost), .crc_mf_mode(crc_mf_mode),
    .prbs_locked(prbs_locked), .sa6_change_interrupt(sa6_change_interrupt)
);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`include "erm_defs.vh"
module testbench;
    typedef struct packed {
        logic [7:0]  ctl;
        logic [3:0]  ev;
        logic [3:0]  n;
        logic        fsl;
        logic        mf;
        logic [2:0]  ci;
        logic [15:0] exp;
    } erm_row_t;
    logic        mclk, rst_n, wr_stb, rd_stb, fsl, mf, alarm, svc_v, svc_si, prbs;
    logic [7:0]  addr, wdata, d;
    logic [15:0] v;
    logic [9:0]  ev;
    logic [3:0]  svc_f;
    logic [4:0]  svc_nat;
    wire  [7:0]  rdata;
    wire         chg;
    int          miscompares = 0, n_tests = 0, n_chg = 0, i, k;
    logic [3:0]  pats [6] = '{4'h8, 4'ha, 4'hc, 4'he, 4'hf, 4'h5};
    logic [2:0]  pbit [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
    logic [7:0]  radr [4] = '{8'h00, 8'h01, 8'h02, 8'h30};
    logic [7:0]  rexp [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
    erm_row_t    rows [10] = '{
        '{8'h00, 4'h0, 4'h5, 1'b0, 1'b1, 3'h0, 16'h0005},
        '{8'h00, 4'h0, 4'h5, 1'b1, 1'b1, 3'h0, 16'h0000},
        '{8'h00, 4'h2, 4'h4, 1'b0, 1'b1, 3'h1, 16'h0000},
        '{8'h18, 4'h2, 4'h4, 1'b0, 1'b1, 3'h1, 16'h0004},
        '{8'h1c, 4'h3, 4'h3, 1'b0, 1'b1, 3'h1, 16'h0003},
        '{8'h08, 4'h2, 4'h2, 1'b0, 1'b1, 3'h1, 16'h0002},
        '{8'h10, 4'h4, 4'h6, 1'b0, 1'b1, 3'h1, 16'h0006},
        '{8'h00, 4'h5, 4'h3, 1'b0, 1'b1, 3'h2, 16'h0003},
        '{8'h00, 4'h5, 4'h3, 1'b0, 1'b0, 3'h2, 16'h0000},
        '{8'h00, 4'h5, 4'h3, 1'b1, 1'b1, 3'h2, 16'h0000}};

    erm_top #(.ALARM_TICK_CYCLES(8)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .frame_sync_lost(fsl), .multiframe_sync_lost(fsl),
        .crc_mf_mode(mf), .alarm_sim(alarm), .fas_error(ev[0]), .rx_bit_tick(ev[1]),
        .hdb3_violation(ev[2]), .hdb3_violation_ext(ev[3]), .bipolar_violation(ev[4]),
        .crc_error(ev[5]), .submultiframe_end(ev[6]), .multiframe_begin_interrupt(ev[7]),
        .alignment_change(ev[8]), .one_second_interrupt(ev[9]), .svc_bit_valid(svc_v),
        .svc_frame_num(svc_f), .svc_spare_bit(svc_si), .svc_national_bits(svc_nat),
        .prbs_locked(prbs), .sa6_change_interrupt(chg));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (chg === 1'b1)
            n_chg <= n_chg + 1;

// ========
// bus and stimulus tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] x);
        addr   <= a;
        wdata  <= x;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask

    task pulse(input logic [3:0] idx, input logic [3:0] n);
        repeat (n)
        begin
            ev[idx] <= 1'b1;
            @(posedge mclk);
            ev[idx] <= 1'b0;
            idle(1);
        end
    endtask

    // low byte first: the high byte read ends the frozen access
    task rdraw(input logic [2:0] ci);
        rd(8'h03 + {4'h0, ci, 1'b0});
        v[7:0] = d;
        rd(8'h04 + {4'h0, ci, 1'b0});
        v[15:8] = d;
    endtask

    task clr(input logic [2:0] ci);
        wr(`ERM_ADR_FREEZE, 8'h01 << ci);
        rd(8'h04 + {4'h0, ci, 1'b0});
    endtask

    task rdcnt(input logic [2:0] ci);
        idle(2);
        wr(`ERM_ADR_FREEZE, 8'h01 << ci);
        rdraw(ci);
        rd(`ERM_ADR_FREEZE);
        chk({15'h0000, d[ci]}, 16'h0000);
    endtask

    task mframe(input logic [3:0] p6, input logic [7:0] sa);
        for (int f = 0; f < 16; f++)
        begin
            svc_f   <= f[3:0];
            svc_si  <= (f != 13);
            svc_nat <= {{2{sa[f/2]}}, p6[3 - (f/2) % 4], {2{sa[f/2]}}};
            svc_v   <= 1'b1;
            @(posedge mclk);
            svc_v   <= 1'b0;
            #1;
        end
        pulse(4'h7, 4'h1);
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

// ========
// main sequence
    initial
    begin
        {wr_stb, rd_stb, fsl, mf, alarm, svc_v, svc_si, prbs} = 8'h00;
        {addr, wdata, ev, svc_f, svc_nat} = 35'h0;
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        idle(2);
        wr(8'h30, 8'hff);
        for (i = 0; i < 4; i++)
        begin
            rd(radr[i]);
            chk({8'h00, d}, {8'h00, rexp[i]});
        end
        for (i = 0; i < 10; i++)
        begin
            wr(`ERM_ADR_CTRL, rows[i].ctl);
            fsl <= rows[i].fsl;
            mf  <= rows[i].mf;
            clr(rows[i].ci);
            pulse(rows[i].ev, rows[i].n);
            rdcnt(rows[i].ci);
            chk(v, rows[i].exp);
        end
        // alarm simulation: time, bit and submultiframe driven counts
        wr(`ERM_ADR_CTRL, 8'h18);
        fsl <= 1'b0;
        for (i = 0; i < 4; i++)
            clr(i[2:0]);
        alarm <= 1'b1;
        pulse(4'h1, 4'h8);
        pulse(4'h6, 4'h3);
        alarm <= 1'b0;
        rdcnt(3'h1);
        chk(v, 16'h0002);
        for (i = 2; i < 4; i++)
        begin
            rdcnt(i[2:0]);
            chk(v, 16'h0003);
        end
        rdcnt(3'h0);
        chk({15'h0000, v >= 16'h0001 && v <= 16'h0004}, 16'h0001);
        // alignment changes saturate in the two low bits
        wr(`ERM_ADR_CTRL, 8'h02);
        clr(3'h4);
        pulse(4'h8, 4'h5);
        fsl <= 1'b1;
        pulse(4'h7, 4'h2);
        fsl <= 1'b0;
        rdcnt(3'h4);
        chk({8'h00, v[7:0]}, 16'h000b);
        // latch mode: second tick latches, then clears
        wr(`ERM_ADR_CTRL, 8'h01);
        pulse(4'h0, 4'h3);
        pulse(4'h9, 4'h1);
        pulse(4'h0, 4'h1);
        idle(2);
        rdraw(3'h0);
        chk(v, 16'h0003);
        pulse(4'h9, 4'h1);
        idle(2);
        rdraw(3'h0);
        chk(v, 16'h0001);
        // national bits, spare bits, e-bits over one multiframe
        wr(`ERM_ADR_CTRL, 8'h40);
        clr(3'h3);
        mframe(4'hf, 8'ha5);
        for (i = 0; i < 5; i++)
        begin
            rd(`ERM_ADR_SA + i[7:0]);
            chk({8'h00, d}, (i == 2) ? 16'h00ff : 16'h00a5);
        end
        rd(`ERM_ADR_SPARE);
        chk({8'h00, d}, 16'h0005);
        rdcnt(3'h3);
        chk(v, 16'h0001);
        // sa6 pattern classes, confirmed after three groups
        rd(`ERM_ADR_SA6ST);
        k = n_chg;
        for (i = 0; i < 6; i++)
        begin
            mframe(pats[i], 8'h00);
            mframe(pats[i], 8'h00);
            rd(`ERM_ADR_SA6ST);
            chk({8'h00, d}, 16'h0001 << pbit[i]);
        end
        rd(`ERM_ADR_SA6ST);
        chk({8'h00, d}, 16'h0000);
        chk(n_chg - k, 16'h0006);
        fsl <= 1'b1;
        k = n_chg;
        mframe(4'h8, 8'h00);
        mframe(4'h8, 8'h00);
        rd(`ERM_ADR_SA6ST);
        rd(`ERM_ADR_SA6ST);
        chk({8'h00, d}, 16'h0000);
        chk(n_chg - k, 16'h0000);
        wr(`ERM_ADR_CTRL, 8'h20);
        for (i = 1; i >= 0; i--)
        begin
            prbs <= i[0];
            idle(3);
            rd(`ERM_ADR_SPARE);
            chk({15'h0000, d[3]}, {15'h0000, i[0]});
        end
        print_verdict;
    end
endmodule // testbench
